// ---- pkg/ufc_pkg.sv ----
package ufc_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int unsigned APB_AW = 18;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned FN_W   = 11;

    // ****************************************************************
    // Register indices (byte address = index * 4)
    // ****************************************************************
    localparam logic [15:0] IDX_AUX     = 16'hFFF9;
    localparam logic [15:0] IDX_FN_HIGH = 16'hFFFA;
    localparam logic [15:0] IDX_FN_LOW  = 16'hFFFB;
    localparam logic [15:0] IDX_CTRL    = 16'hFFFC;
    localparam logic [15:0] IDX_MASK    = 16'hFFFD;
    localparam logic [15:0] IDX_STATUS  = 16'hFFFE;
    localparam logic [15:0] IDX_VECTOR  = 16'hFFFF;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int unsigned CTL_CONNECT = 7;
    localparam int unsigned CTL_FEN     = 6;
    localparam int unsigned CTL_WAKEUP  = 5;
    localparam int unsigned CTL_SCOPE   = 4;
    localparam int unsigned CTL_CONFIRM = 0;
    localparam logic [7:0]  CTL_RESET   = 8'h00;

    // ****************************************************************
    // Event positions, shared by status and mask
    // ****************************************************************
    localparam int unsigned EV_BUS_RESET = 7;
    localparam int unsigned EV_SUSPEND   = 6;
    localparam int unsigned EV_RESUME    = 5;
    localparam int unsigned EV_SOF       = 4;
    localparam int unsigned EV_PSEUDO_FRAME_START      = 3;
    localparam int unsigned EV_SETUP     = 2;
    localparam int unsigned EV_OVERWRITE = 0;
    localparam logic [7:0]  EV_IMPL      = 8'hFD;
    localparam logic [7:0]  MASK_RESET   = 8'h00;

    // ****************************************************************
    // Auxiliary status fields
    // ****************************************************************
    localparam int unsigned AUX_SPURIOUS = 0;
    localparam int unsigned AUX_LOCKED   = 1;
    localparam int unsigned AUX_USB_RST  = 2;
    localparam logic [10:0] FN_RESET     = 11'h000;

endpackage

// ---- pkg/ufc_evt_if.sv ----
`timescale 1ns/1ps
// Event and frame signals between the register bank and its helpers
interface ufc_evt_if;
    logic [7:0]  evt_set;
    logic        flag_clr;
    logic [7:0]  flags;
    logic        sof;
    logic        pseudo_frame_start;
    logic        locked;
    logic [10:0] sof_fn;
    logic [10:0] frame_no;

    modport bank  (output evt_set, flag_clr, sof, pseudo_frame_start, locked, sof_fn,
                   input flags, frame_no);
    modport flag  (input evt_set, flag_clr, output flags);
    modport frame (input sof, pseudo_frame_start, locked, sof_fn, output frame_no);
endinterface

// ---- rtl/ufc_event_flags.sv ----
`timescale 1ns/1ps
module ufc_event_flags
    import ufc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    ufc_evt_if.flag   ev
);

    logic [7:0] flags_r;

    // Sticky flags; a new event beats a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flags_r <= 8'h00;
        end else begin
            flags_r <= ((flags_r & ~{8{ev.flag_clr}}) | ev.evt_set) & EV_IMPL;
        end
    end

    assign ev.flags = flags_r;

endmodule // ufc_event_flags

// ---- rtl/ufc_frame_counter.sv ----
`timescale 1ns/1ps
module ufc_frame_counter
    import ufc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    ufc_evt_if.frame  ev
);

    logic [10:0] frame_r;

    // Host value wins; free-run only while unlocked
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            frame_r <= FN_RESET;
        end else if (ev.sof) begin
            frame_r <= ev.sof_fn;
        end else if (ev.pseudo_frame_start && !ev.locked) begin
            frame_r <= frame_r + 11'h001;  // Wraps at 2047 like the host count
        end
    end

    assign ev.frame_no = frame_r;

endmodule // ufc_frame_counter

// ---- rtl/ufc_regs.sv ----
`timescale 1ns/1ps
// Function
// - one mask bit per USB event gates that event's interrupt
// - connect bit drives pull-up enable; USB reset leaves it alone
// - function-enable gates transactions and clears on USB reset
// - wake-up bit requests upstream resume signalling
// - scope bit widens USB reset to wake-up, mask and core reset, sparing connect, scope and confirm
// - scope bit also drives external reset during USB reset
// - shadow clear needs confirm bit first, else counted spurious
// - confirm bit survives USB reset
// - low frame byte tracks bits 7:0 of SOF frame number
// - unlocked timer increments frame number on pseudo SOF
// - hardware sets event flags; vector write clears all
// - upper three frame bits sit in separate high byte
module ufc_regs
    import ufc_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // APB slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [APB_AW-1:0]    paddr_i,
    input  wire logic [DATA_W-1:0]    pwdata_i,
    output logic      [DATA_W-1:0]    prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // USB events from the serial engine, one-cycle pulses
    input  wire logic                 bus_reset_event_i,
    input  wire logic                 suspend_event_i,
    input  wire logic                 resume_event_i,
    input  wire logic                 sof_event_i,
    input  wire logic                 pseudo_frame_start_i,
    input  wire logic                 setup_event_i,
    input  wire logic                 setup_overwrite_event_i,
    input  wire logic [FN_W-1:0]      sof_frame_number_i,
    input  wire logic                 frame_timer_locked_i,
    input  wire logic                 usb_reset_i,
    // Shadow-ROM clear attempt from the memory config register
    input  wire logic                 shadow_clear_req_i,
    // Controls toward the rest of the chip
    output logic                      usb_irq_o,
    output logic                      dplus_pullup_out_o,
    output logic                      dplus_pullup_oe_o,
    output logic                      function_enable_bit_o,
    output logic                      remote_wakeup_request_o,
    output logic                      external_reset_out_o,
    output logic                      core_reset_req_o,
    output logic                      shadow_clear_grant_o
);

    // ****************************************************************
    // Local state
    // ****************************************************************
    ufc_evt_if ev ();

    logic                connect_r;
    logic                fen_r;
    logic                wakeup_r;
    logic                scope_r;
    logic                confirm_r;
    logic [7:0]          mask_r;
    logic                spurious_r;
    logic                ext_rst_r;
    logic                core_rst_r;
    logic                grant_r;
    logic [DATA_W-1:0]   prdata_r;
    logic [DATA_W-1:0]   rd_nxt;
    logic [15:0]         idx;
    logic                hit;
    logic                setup_ph;
    logic                access_ph;
    logic                wr_en;
    logic                wr_ctrl;
    logic                wr_mask;
    logic                wr_vector;
    logic                wr_aux;
    logic                scoped_rst;
    logic [7:0]          ctrl_view;
    logic [7:0]          aux_view;

    // ****************************************************************
    // APB decode
    // ****************************************************************

    // Word index; the low two address bits are ignored
    assign idx       = paddr_i[APB_AW-1:2];
    assign setup_ph  = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i;

    // Known registers; anything else answers with an error
    always_comb begin
        unique case (idx)
            IDX_AUX,
            IDX_FN_HIGH,
            IDX_FN_LOW,
            IDX_CTRL,
            IDX_MASK,
            IDX_STATUS,
            IDX_VECTOR: hit = 1'b1;
            default:    hit = 1'b0;
        endcase
    end

    // Zero wait states; a single-cycle access phase is enough here
    assign pready_o  = 1'b1;
    assign pslverr_o = access_ph && !hit;

    // Writes land only in the access phase of a mapped address
    assign wr_en     = access_ph && pwrite_i && hit;
    assign wr_ctrl   = wr_en && (idx == IDX_CTRL);
    assign wr_mask   = wr_en && (idx == IDX_MASK);
    assign wr_vector = wr_en && (idx == IDX_VECTOR);
    assign wr_aux    = wr_en && (idx == IDX_AUX);

    // ****************************************************************
    // USB reset scope
    // ****************************************************************

    assign scoped_rst = usb_reset_i && scope_r;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ext_rst_r <= 1'b0;
        end else begin
            ext_rst_r <= scoped_rst;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            core_rst_r <= 1'b0;
        end else begin
            core_rst_r <= scoped_rst;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            connect_r <= CTL_RESET[CTL_CONNECT];
        end else if (wr_ctrl) begin
            connect_r <= pwdata_i[CTL_CONNECT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            fen_r <= CTL_RESET[CTL_FEN];
        end else if (usb_reset_i) begin
            fen_r <= 1'b0;  // Reset beats a same-cycle firmware write
        end else if (wr_ctrl) begin
            fen_r <= pwdata_i[CTL_FEN];
        end
    end

    // firmware or a scoped USB reset clears it; no timeout enforced here
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wakeup_r <= CTL_RESET[CTL_WAKEUP];
        end else if (scoped_rst) begin
            wakeup_r <= 1'b0;
        end else if (wr_ctrl) begin
            wakeup_r <= pwdata_i[CTL_WAKEUP];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            scope_r <= CTL_RESET[CTL_SCOPE];
        end else if (wr_ctrl) begin
            scope_r <= pwdata_i[CTL_SCOPE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            confirm_r <= CTL_RESET[CTL_CONFIRM];
        end else if (wr_ctrl) begin
            confirm_r <= pwdata_i[CTL_CONFIRM];
        end
    end

    // Reserved control bits read as zero
    always_comb begin
        ctrl_view              = 8'h00;
        ctrl_view[CTL_CONNECT] = connect_r;
        ctrl_view[CTL_FEN]     = fen_r;
        ctrl_view[CTL_WAKEUP]  = wakeup_r;
        ctrl_view[CTL_SCOPE]   = scope_r;
        ctrl_view[CTL_CONFIRM] = confirm_r;
    end

    // ****************************************************************
    // Shadow-ROM clear guard
    // ****************************************************************

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            grant_r <= 1'b0;
        end else begin
            grant_r <= shadow_clear_req_i && confirm_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            spurious_r <= 1'b0;
        end else if (shadow_clear_req_i && !confirm_r) begin
            spurious_r <= 1'b1;  // New attempt wins over a clear
        end else if (wr_aux && pwdata_i[AUX_SPURIOUS]) begin
            spurious_r <= 1'b0;
        end
    end

    always_comb begin
        aux_view               = 8'h00;
        aux_view[AUX_SPURIOUS] = spurious_r;
        aux_view[AUX_LOCKED]   = frame_timer_locked_i;
        aux_view[AUX_USB_RST]  = usb_reset_i;
    end

    // ****************************************************************
    // Interrupt mask and event flags
    // ****************************************************************

    // reserved bit 1 held at zero
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mask_r <= MASK_RESET;
        end else if (scoped_rst) begin
            mask_r <= MASK_RESET;
        end else if (wr_mask) begin
            mask_r <= pwdata_i[7:0] & EV_IMPL;
        end
    end

    always_comb begin
        ev.evt_set               = 8'h00;
        ev.evt_set[EV_BUS_RESET] = bus_reset_event_i;
        ev.evt_set[EV_SUSPEND]   = suspend_event_i;
        ev.evt_set[EV_RESUME]    = resume_event_i;
        ev.evt_set[EV_SOF]       = sof_event_i;
        ev.evt_set[EV_PSEUDO_FRAME_START]      = pseudo_frame_start_i;
        ev.evt_set[EV_SETUP]     = setup_event_i;
        ev.evt_set[EV_OVERWRITE] = setup_overwrite_event_i;
    end

    assign ev.flag_clr = wr_vector;

    ufc_event_flags u_flags (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ev      (ev.flag)
    );

    assign usb_irq_o = |(ev.flags & mask_r);

    // ****************************************************************
    // Frame number
    // ****************************************************************

    assign ev.sof    = sof_event_i;
    assign ev.pseudo_frame_start   = pseudo_frame_start_i;
    assign ev.locked = frame_timer_locked_i;
    assign ev.sof_fn = sof_frame_number_i;

    ufc_frame_counter u_frame (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ev      (ev.frame)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************

    // Read mux; vector register reads as zero
    always_comb begin
        rd_nxt = '0;
        unique case (idx)
            IDX_AUX:     rd_nxt[7:0] = aux_view;
            IDX_FN_HIGH: rd_nxt[2:0] = ev.frame_no[10:8];
            IDX_FN_LOW:  rd_nxt[7:0] = ev.frame_no[7:0];
            IDX_CTRL:    rd_nxt[7:0] = ctrl_view;
            IDX_MASK:    rd_nxt[7:0] = mask_r;
            IDX_STATUS:  rd_nxt[7:0] = ev.flags;
            default:     rd_nxt      = '0;
        endcase
    end

    // Captured in setup so data is stable through access
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            prdata_r <= '0;
        end else if (setup_ph && !pwrite_i) begin
            prdata_r <= rd_nxt;
        end
    end

    assign prdata_o = prdata_r;

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign dplus_pullup_out_o      = connect_r;
    assign dplus_pullup_oe_o       = connect_r;
    assign function_enable_bit_o   = fen_r;
    assign remote_wakeup_request_o = wakeup_r;
    assign external_reset_out_o    = ext_rst_r;
    assign core_reset_req_o        = core_rst_r;
    assign shadow_clear_grant_o    = grant_r;

endmodule // ufc_regs

// ---- testbench/ufc_regs_sva.sv ----
`timescale 1ns/1ps
module ufc_regs_sva
    import ufc_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_b_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [DATA_W-1:0] prdata_o,
    input wire logic              pslverr_o,
    input wire logic              evt_any_i,
    input wire logic              usb_reset_i,
    input wire logic              shadow_clear_req_i,
    input wire logic              usb_irq_o,
    input wire logic              dplus_pullup_out_o,
    input wire logic              dplus_pullup_oe_o,
    input wire logic              function_enable_bit_o,
    input wire logic              remote_wakeup_request_o,
    input wire logic              external_reset_out_o,
    input wire logic              core_reset_req_o,
    input wire logic              shadow_clear_grant_o
);
    // Completed write access
    wire logic wr_acc = psel_i & penable_i & pwrite_i;
    wire logic [15:0] idx = paddr_i[17:2];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    err_phase_a: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("slave error outside access");
    rd_upper_a: assert property (psel_i && !penable_i |=> prdata_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    irq_mask_a: assert property (wr_acc && idx == IDX_MASK && pwdata_i[7:0] == 8'h00
        |=> !usb_irq_o)
        else $error("irq with zero mask");
    vec_clr_a: assert property (wr_acc && idx == IDX_VECTOR && !evt_any_i |=> !usb_irq_o)
        else $error("irq after vector write");
    pullup_pair_a: assert property (dplus_pullup_out_o == dplus_pullup_oe_o)
        else $error("pull-up drive and enable differ");
    conn_hold_a: assert property (usb_reset_i && !wr_acc |=> $stable(dplus_pullup_oe_o))
        else $error("connect changed by usb reset");
    fen_clr_a: assert property (usb_reset_i |=> !function_enable_bit_o)
        else $error("function enable kept in usb reset");
    ext_cause_a: assert property (external_reset_out_o |-> $past(usb_reset_i))
        else $error("reset out without usb reset");
    ext_drop_a: assert property ($fell(usb_reset_i) |=> !external_reset_out_o)
        else $error("reset out stuck");
    core_same_a: assert property (core_reset_req_o == external_reset_out_o)
        else $error("core reset differs");
    wake_clr_a: assert property (external_reset_out_o && !$past(wr_acc)
        |-> !remote_wakeup_request_o)
        else $error("wake-up kept in chip reset");
    grant_cause_a: assert property (shadow_clear_grant_o |-> $past(shadow_clear_req_i))
        else $error("grant without attempt");

    cover property (wr_acc && idx == IDX_CTRL);
    cover property (external_reset_out_o);
    cover property (shadow_clear_grant_o);
    cover property (usb_irq_o);
endmodule // ufc_regs_sva

bind ufc_regs ufc_regs_sva u_sva (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .usb_reset_i(usb_reset_i), .shadow_clear_req_i(shadow_clear_req_i),
    .evt_any_i(bus_reset_event_i | suspend_event_i | resume_event_i | sof_event_i
        | pseudo_frame_start_i | setup_event_i | setup_overwrite_event_i),
    .usb_irq_o(usb_irq_o), .dplus_pullup_out_o(dplus_pullup_out_o),
    .dplus_pullup_oe_o(dplus_pullup_oe_o), .function_enable_bit_o(function_enable_bit_o),
    .remote_wakeup_request_o(remote_wakeup_request_o),
    .external_reset_out_o(external_reset_out_o), .core_reset_req_o(core_reset_req_o),
    .shadow_clear_grant_o(shadow_clear_grant_o));

// ---- testbench/ufc_host_model.sv ----
`timescale 1ns/1ps
module ufc_host_model
    import ufc_pkg::*;
(
    input  wire logic   clk_i,
    output logic [7:0]  evt_o,
    output logic [10:0] fn_o,
    output logic        locked_o,
    output logic        usb_rst_o
);
    initial begin
        evt_o = 8'h00;
        fn_o = 11'h2AA;
        locked_o = 1'b1;
        usb_rst_o = 1'b0;
    end
    // One-cycle event pulses
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_i);
        evt_o <= m;
        @(posedge clk_i);
        evt_o <= 8'h00;
    endtask
    task automatic sof(input logic [10:0] n);
        @(posedge clk_i);
        fn_o <= n;
        evt_o <= 8'h01 << EV_SOF;
        @(posedge clk_i);
        evt_o <= 8'h00;
        fn_o <= ~n; // Not valid outside SOF
    endtask
    task automatic set_lock(input logic l);
        @(posedge clk_i);
        locked_o <= l;
    endtask
    task automatic bus_rst(input int n);
        @(posedge clk_i);
        usb_rst_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        usb_rst_o <= 1'b0;
    endtask
endmodule // ufc_host_model

// ---- testbench/tb_usb_function_control_regs.sv ----
`timescale 1ns/1ps
module tb_usb_function_control_regs
    import ufc_pkg::*;
;
    logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i, sreq, lock, urst;
    logic [17:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [7:0]  evt, q;
    logic [10:0] fn;
    // One net per event line, so every event pin follows its own host bit
    wire logic ev_br = evt[EV_BUS_RESET];
    wire logic ev_su = evt[EV_SUSPEND];
    wire logic ev_re = evt[EV_RESUME];
    wire logic ev_so = evt[EV_SOF];
    wire logic ev_ps = evt[EV_PSEUDO_FRAME_START];
    wire logic ev_st = evt[EV_SETUP];
    wire logic ev_ow = evt[EV_OVERWRITE];
    logic pready_o, pslverr_o, irq, pu, pu_oe, function_enable_bit, wake, ext, core, grant, e;
    int error_cnt, tests_run;
    ufc_host_model host (.clk_i(clk_i), .evt_o(evt), .fn_o(fn), .locked_o(lock),
        .usb_rst_o(urst));
    ufc_regs dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .bus_reset_event_i(ev_br),
        .suspend_event_i(ev_su), .resume_event_i(ev_re),
        .sof_event_i(ev_so), .pseudo_frame_start_i(ev_ps),
        .setup_event_i(ev_st), .setup_overwrite_event_i(ev_ow),
        .sof_frame_number_i(fn), .frame_timer_locked_i(lock), .usb_reset_i(urst),
        .shadow_clear_req_i(sreq), .usb_irq_o(irq), .dplus_pullup_out_o(pu),
        .dplus_pullup_oe_o(pu_oe), .function_enable_bit_o(function_enable_bit),
        .remote_wakeup_request_o(wake), .external_reset_out_o(ext),
        .core_reset_req_o(core), .shadow_clear_grant_o(grant));
    always #2 clk_i = ~clk_i;
    // APB master, waits for pready at each access edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {a, 2'b00};
        pwdata_i <= {24'h000000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin @(posedge clk_i); end while (pready_o !== 1'b1);
        q = prdata_o[7:0];
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] x);
        tests_run++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %0t reg %h exp %h", $time, g, x);
        end
    endtask
    // Pin is read by reference at the falling edge, after the launching edge settles
    task automatic chk_pin(const ref logic g, input logic x);
        @(negedge clk_i);
        tests_run++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %0t pin %b exp %b", $time, g, x);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk_reg(q, x);
    endtask
    // Firmware attempt to clear shadow select
    task automatic shadow_try;
        @(posedge clk_i);
        sreq <= 1'b1;
        @(posedge clk_i);
        sreq <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge clk_i);
        error_cnt++;
        print_verdict();
    end
    initial begin
        {clk_i, rst_b_i, psel_i, penable_i, pwrite_i, sreq} = 6'h00;
        paddr_i = 18'h00000;
        pwdata_i = 32'h00000000;
        error_cnt = 0;
        tests_run = 0;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // *****
        // Reset values and refusals
        // *****
        rd(IDX_FN_LOW, 8'h00);
        rd(IDX_CTRL, 8'h00);
        rd(IDX_MASK, 8'h00);
        rd(16'h0000, 8'h00);
        chk_reg({7'h00, e}, 8'h01);
        apb(1'b1, IDX_MASK, 8'hFF);
        rd(IDX_MASK, 8'hFD);
        // Each event: gated by mask, cleared by vector write
        for (int i = 0; i < 8; i++) begin
            if (EV_IMPL[i]) begin
                apb(1'b1, IDX_MASK, 8'h01 << i);
                host.pulse(EV_IMPL & ~(8'h01 << i));
                chk_pin(irq, 1'b0);
                host.pulse(8'h01 << i);
                chk_pin(irq, 1'b1);
                rd(IDX_STATUS, EV_IMPL);
                apb(1'b1, IDX_VECTOR, 8'h00);
                chk_pin(irq, 1'b0);
                rd(IDX_STATUS, 8'h00);
            end
        end
        apb(1'b1, IDX_MASK, 8'h00);
        // *****
        // USB reset, narrow then wide scope
        // *****
        apb(1'b1, IDX_CTRL, 8'hC1);
        chk_pin(function_enable_bit, 1'b1);
        host.bus_rst(4);
        chk_pin(ext, 1'b0);
        chk_pin(core, 1'b0);
        rd(IDX_CTRL, 8'h81);
        chk_pin(pu_oe, 1'b1);
        apb(1'b1, IDX_MASK, 8'hFD);
        apb(1'b1, IDX_CTRL, 8'hFF);
        rd(IDX_CTRL, 8'hF1);
        host.bus_rst(4);
        chk_pin(ext, 1'b1);
        chk_pin(ext, 1'b0);
        rd(IDX_CTRL, 8'h91);
        rd(IDX_MASK, 8'h00);
        // Wake-up cleared again well inside 625 cycles
        apb(1'b1, IDX_CTRL, 8'h20);
        chk_pin(wake, 1'b1);
        repeat (100) @(posedge clk_i);
        apb(1'b1, IDX_CTRL, 8'h00);
        chk_pin(wake, 1'b0);
        chk_pin(pu, 1'b0);
        // *****
        // Shadow clear confirmation
        // *****
        shadow_try();
        chk_pin(grant, 1'b0);
        rd(IDX_AUX, 8'h03);
        apb(1'b1, IDX_CTRL, 8'h01);
        shadow_try();
        chk_pin(grant, 1'b1);
        // *****
        // Frame number
        // *****
        host.sof(11'h5A3);
        rd(IDX_FN_LOW, 8'hA3);
        rd(IDX_FN_HIGH, 8'h05);
        host.set_lock(1'b0);
        host.pulse(8'h08);
        rd(IDX_FN_LOW, 8'hA4);
        host.set_lock(1'b1);
        host.pulse(8'h08);
        apb(1'b1, IDX_FN_LOW, 8'h55);
        rd(IDX_FN_LOW, 8'hA4);
        host.sof(11'h7FF);
        host.set_lock(1'b0);
        host.pulse(8'h08);
        rd(IDX_FN_LOW, 8'h00);
        rd(IDX_FN_HIGH, 8'h00);
        print_verdict();
    end
endmodule // tb_usb_function_control_regs
